// ===== irp_top.sv
// Notes on behaviour
// - Host interrupt pin floats during reset, then drives high once reset ends.
// - The host interrupt pin signals an interrupt request to the host.
// - Host port outputs float whenever the host port enable pin is low.
// - Each of the four maskable interrupts has its own enable bit.
// - The global mask bit blocks all maskable interrupts at once.
// - Each maskable interrupt latches a flag software can poll and clear.
// - A select bit makes the shared pin NMI or watchdog; NMI after reset.
// - An NMI is always serviced, ignoring enables and the global mask.
// - In watchdog mode the shared pin is both input and output.
// - Acknowledge asserts when an interrupt is accepted and its vector fetched.
// - Acknowledge is driven high throughout reset.
// - Reset aborts execution; release fetches the reset vector at FFFF00h.
// - Hold-designated pins float while an external bus hold is granted.
// - Memory clocks keep running in hold unless their tristate bit is set.
// - Designated pins float in OFF mode: TRST 0, emulation pin zero 1, OFF pin 0.
// - Designated pins float for as long as reset is low.
// - Holders and pulls are enabled per bit, all enabled after reset.
`include "irp_cfg.svh"

module irp_top #(
  parameter int NUM_IRQ = `IRP_NUM_IRQ,
  parameter int BUS_CTRL_W = `IRP_BUSCTRL_W
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Maskable interrupt pins, active low.
  input wire logic [NUM_IRQ-1:0] extIrqN,
  // Interrupt control from the core.
  input wire logic [NUM_IRQ-1:0] irqEnable,
  input wire logic globalIrqMask,
  input wire logic [NUM_IRQ-1:0] flagClear,
  output logic [NUM_IRQ-1:0] irqFlag,
  output logic nmiPending,
  // Vector fetch handshake with the core.
  input wire logic cpuIrqTake,
  output logic irqRequest,
  output logic fetchValid,
  output logic [`IRP_ADDR_W-1:0] fetchAddr,
  output logic coreRunN,
  // Configuration written by the core.
  input wire logic timerSelectWe,
  input wire logic timerSelectData,
  output logic timerSelect,
  input wire logic vectorPageWe,
  input wire logic [`IRP_PAGE_W-1:0] vectorPageData,
  input wire logic extBusCtrlWe,
  input wire logic [BUS_CTRL_W-1:0] extBusCtrlData,
  output logic [BUS_CTRL_W-1:0] extBusCtrl,
  // Shared interrupt and watchdog pin.
  input wire logic sharedIrqWatchdogPinIn,
  output logic sharedIrqWatchdogPinOut,
  output logic sharedIrqWatchdogPinOe,
  input wire logic watchdogDriveEn,
  input wire logic watchdogDriveValue,
  output logic watchdogPinIn,
  // Interrupt acknowledge pin, active low.
  output logic irqAcknowledgeN,
  output logic irqAcknowledgeOe,
  // Host port.
  input wire logic hostPortEnablePin,
  input wire logic hostIrqSet,
  input wire logic hostIrqClear,
  output logic hostInterruptOutN,
  output logic hostInterruptOe,
  output logic hostPortOe,
  // Bus hold and memory clocks.
  input wire logic holdGrant,
  input wire logic [1:0] extClockHoldTristate,
  output logic [1:0] extMemClockOe,
  output logic holdPinOe,
  // Test and emulation pins.
  input wire logic trstN,
  input wire logic emulationPinZero,
  input wire logic emulationOffPinN
);

  localparam int SYNC_W = NUM_IRQ + 1;
  localparam int IDX_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    irp_pkg::irp_state_type state;
    logic rstMeta;
    logic rstDone;
    logic [NUM_IRQ-1:0] irqPrev;
    logic [NUM_IRQ-1:0] irqFlag;
    logic nmiPrev;
    logic nmiPending;
    logic timerSelect;
    logic [`IRP_PAGE_W-1:0] vectorPage;
    logic [BUS_CTRL_W-1:0] extBusCtrl;
    logic hostIntLevel;
    logic ackN;
    logic fetchValid;
    logic [`IRP_ADDR_W-1:0] fetchAddr;
  } irp_core_type;

  localparam irp_core_type CORE_RESET = '{
    state: irp_pkg::IRP_BOOT,
    rstMeta: 1'h0,
    rstDone: 1'h0,
    irqPrev: {NUM_IRQ{`IRP_PIN_IDLE}},
    irqFlag: '0,
    nmiPrev: `IRP_PIN_IDLE,
    nmiPending: 1'h0,
    timerSelect: `IRP_SELECT_NMI,
    vectorPage: `IRP_RESET_PAGE,
    extBusCtrl: {BUS_CTRL_W{`IRP_BUSCTRL_RESET}},
    hostIntLevel: `IRP_HOSTINT_IDLE,
    ackN: `IRP_ACK_IDLE,
    fetchValid: 1'h0,
    fetchAddr: '0
  };

  irp_core_type st;
  irp_core_type next_st;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [`IRP_ADDR_W-1:0] vectorAddr(
    input logic [`IRP_PAGE_W-1:0] page,
    input logic [`IRP_VEC_W-1:0] vec
  );
    return {page, vec, `IRP_VEC_PAD};
  endfunction

  // Lowest numbered pending source wins.
  function automatic logic [IDX_W-1:0] lowestSet(input logic [NUM_IRQ-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  irp_sync_if #(.W(SYNC_W)) syncBus();

  assign syncBus.raw = {sharedIrqWatchdogPinIn, extIrqN};

  irp_sync #(.W(SYNC_W)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .bus(syncBus.chain)
  );

  logic [NUM_IRQ-1:0] syncIrq;
  logic syncShared;

  assign syncIrq = syncBus.synced[NUM_IRQ-1:0];
  assign syncShared = syncBus.synced[NUM_IRQ];

  // ****************************************************************
  // Request decode.
  // ****************************************************************
  logic offMode;
  logic [NUM_IRQ-1:0] irqFall;
  logic nmiFall;
  logic [NUM_IRQ-1:0] maskedReq;
  logic [IDX_W-1:0] pickIdx;
  logic accept;

  assign offMode = !trstN && emulationPinZero && !emulationOffPinN;
  assign irqFall = st.rstDone ? (st.irqPrev & ~syncIrq) : '0;
  assign nmiFall = st.rstDone && (st.timerSelect == `IRP_SELECT_NMI)
                   && st.nmiPrev && !syncShared;
  assign maskedReq = globalIrqMask ? '0 : (st.irqFlag & irqEnable);
  assign pickIdx = lowestSet(maskedReq);
  assign irqRequest = (st.state == irp_pkg::IRP_RUN)
                      && (st.nmiPending || (|maskedReq));
  assign accept = irqRequest && cpuIrqTake;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb
  begin
    logic [NUM_IRQ-1:0] takeMask;
    logic takeNmi;
    takeMask = '0;
    takeNmi = 1'h0;
    next_st = st;
    next_st.rstMeta = 1'h1;
    next_st.rstDone = st.rstMeta;
    next_st.irqPrev = syncIrq;
    next_st.nmiPrev = syncShared;
    next_st.fetchValid = 1'h0;
    next_st.ackN = `IRP_ACK_IDLE;
    case (st.state)
      irp_pkg::IRP_BOOT:
      begin
        if (st.rstDone)
        begin
          next_st.fetchValid = 1'h1;
          next_st.fetchAddr = vectorAddr(`IRP_RESET_PAGE, `IRP_VEC_RESET);
          next_st.state = irp_pkg::IRP_RUN;
        end
      end
      irp_pkg::IRP_RUN:
      begin
        if (accept)
        begin
          next_st.fetchValid = 1'h1;
          next_st.ackN = 1'h0;
          next_st.state = irp_pkg::IRP_ACK;
          if (st.nmiPending)
          begin
            takeNmi = 1'h1;
            next_st.fetchAddr = vectorAddr(st.vectorPage, `IRP_VEC_NMI);
          end
          else
          begin
            takeMask[pickIdx] = 1'h1;
            next_st.fetchAddr = vectorAddr(st.vectorPage,
                                           `IRP_VEC_INT0 + `IRP_VEC_W'(pickIdx));
          end
        end
      end
      irp_pkg::IRP_ACK:
      begin
        next_st.state = irp_pkg::IRP_RUN;
      end
      default:
      begin
        next_st.state = irp_pkg::IRP_BOOT;
      end
    endcase
    // A new edge in the cycle of a clear keeps its flag.
    next_st.irqFlag = (st.irqFlag & ~(flagClear | takeMask)) | irqFall;
    next_st.nmiPending = (st.nmiPending && !takeNmi) || nmiFall;
    if (st.rstDone && timerSelectWe)
    begin
      next_st.timerSelect = timerSelectData;
    end
    if (st.rstDone && vectorPageWe)
    begin
      next_st.vectorPage = vectorPageData;
    end
    if (st.rstDone && extBusCtrlWe)
    begin
      next_st.extBusCtrl = extBusCtrlData;
    end
    if (st.rstDone && hostIrqSet)
    begin
      next_st.hostIntLevel = 1'h0;
    end
    else if (hostIrqClear)
    begin
      next_st.hostIntLevel = `IRP_HOSTINT_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= CORE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs and pad control.
  // ****************************************************************
  assign irqFlag = st.irqFlag;
  assign nmiPending = st.nmiPending;
  assign fetchValid = st.fetchValid;
  assign fetchAddr = st.fetchAddr;
  assign coreRunN = !st.rstDone;
  assign timerSelect = st.timerSelect;
  assign extBusCtrl = st.extBusCtrl;

  assign hostPortOe = st.rstDone && hostPortEnablePin && !offMode;
  assign hostInterruptOe = hostPortOe;
  assign hostInterruptOutN = st.hostIntLevel;

  assign irqAcknowledgeN = st.ackN;
  assign irqAcknowledgeOe = !offMode;

  assign watchdogPinIn = syncShared;
  assign sharedIrqWatchdogPinOut = watchdogDriveValue;
  assign sharedIrqWatchdogPinOe = st.rstDone && !offMode && watchdogDriveEn
                                  && (st.timerSelect == `IRP_SELECT_WDT);

  assign holdPinOe = st.rstDone && !holdGrant && !offMode;
  assign extMemClockOe = offMode ? 2'h0
                         : ~({2{holdGrant}} & extClockHoldTristate);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence sAccept;
    irqRequest && cpuIrqTake;
  endsequence

  sequence sAckPulse;
    !irqAcknowledgeN && fetchValid ##1 irqAcknowledgeN;
  endsequence

  a_host_interrupt_out_reset_float: assert property (!st.rstDone |-> !hostInterruptOe && !hostPortOe)
    else $error("host interrupt driven during reset");

  a_host_interrupt_out_release_high: assert property ($rose(st.rstDone) |-> hostInterruptOutN
    && (hostInterruptOe == (hostPortEnablePin && !offMode)))
    else $error("host interrupt not high after reset");

  a_host_interrupt_out_set_low: assert property (st.rstDone && hostIrqSet |=> !hostInterruptOutN)
    else $error("host interrupt not asserted");

  a_port_disable: assert property (!hostPortEnablePin |-> !hostPortOe && !hostInterruptOe)
    else $error("host port driven while disabled");

  a_enable_gate: assert property ((st.irqFlag & irqEnable) == '0 && !st.nmiPending
    |-> !irqRequest)
    else $error("request from disabled source");

  a_global_mask: assert property (globalIrqMask && !st.nmiPending |-> !irqRequest)
    else $error("request through global mask");

  for (genvar gi = 0; gi < NUM_IRQ; gi++)
  begin : g_flag
    a_flag_latch: assert property (st.rstDone && $fell(syncIrq[gi]) |=> st.irqFlag[gi])
      else $error("interrupt edge lost");
  end

  a_nmi_default: assert property ($rose(st.rstDone) |-> st.timerSelect == `IRP_SELECT_NMI)
    else $error("shared pin not in interrupt mode");

  a_nmi_always: assert property (st.state == irp_pkg::IRP_RUN && st.nmiPending
    |-> irqRequest)
    else $error("nmi not requested");

  a_wdt_drive: assert property (st.timerSelect == `IRP_SELECT_NMI |-> !sharedIrqWatchdogPinOe)
    else $error("shared pin driven in interrupt mode");

  a_ack_pulse: assert property (sAccept |=> sAckPulse)
    else $error("acknowledge pulse wrong");

  a_ack_reset_high: assert property (!st.rstDone |-> irqAcknowledgeN
    && (irqAcknowledgeOe == !offMode))
    else $error("acknowledge not high in reset");

  a_reset_vector: assert property ($rose(st.rstDone) |=> fetchValid
    && fetchAddr == vectorAddr(`IRP_RESET_PAGE, `IRP_VEC_RESET))
    else $error("reset vector not fetched");

  a_hold_float: assert property (holdGrant |-> !holdPinOe)
    else $error("hold pin driven in hold");

  a_hold_clock: assert property (holdGrant && !offMode
    |-> extMemClockOe == ~extClockHoldTristate)
    else $error("memory clock wrong in hold");

  a_off_mode: assert property (offMode |-> !hostInterruptOe && !irqAcknowledgeOe
    && !sharedIrqWatchdogPinOe && extMemClockOe == 2'h0)
    else $error("pin driven in off mode");

  a_busctrl_reset: assert property ($rose(st.rstDone) |-> &st.extBusCtrl)
    else $error("bus control not all enabled");

endmodule

// ===== irp_cfg.svh
`ifndef IRP_CFG_SVH
`define IRP_CFG_SVH

// ****************************************************************
// Counts and widths.
// ****************************************************************
`define IRP_NUM_IRQ 4
`define IRP_BUSCTRL_W 16
`define IRP_PAGE_W 16
`define IRP_VEC_W 5
`define IRP_ADDR_W 24

// ****************************************************************
// Vector numbers and the reset page.
// ****************************************************************
`define IRP_RESET_PAGE 16'hffff
`define IRP_VEC_RESET 5'h00
`define IRP_VEC_NMI 5'h01
`define IRP_VEC_INT0 5'h02
`define IRP_VEC_PAD 3'h0

// ****************************************************************
// Reset and idle values.
// ****************************************************************
`define IRP_SELECT_NMI 1'h0
`define IRP_SELECT_WDT 1'h1
`define IRP_PIN_IDLE 1'h1
`define IRP_HOSTINT_IDLE 1'h1
`define IRP_ACK_IDLE 1'h1
`define IRP_BUSCTRL_RESET 1'h1

`endif

// ===== irp_pkg.sv
package irp_pkg;

  // Sequencing of the vector fetch logic.
  typedef enum logic [1:0] {
    IRP_BOOT,
    IRP_RUN,
    IRP_ACK
  } irp_state_type;

endpackage

// ===== irp_sync_if.sv
interface irp_sync_if #(
  parameter int W = 5
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport owner (output raw, input synced);
  modport chain (input raw, output synced);
endinterface

// ===== irp_sync.sv
`include "irp_cfg.svh"

module irp_sync #(
  parameter int W = 5
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Pins in, stable copies out.
  irp_sync_if.chain bus
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } irp_chain_type;

  irp_chain_type st;
  irp_chain_type next_st;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_st = st;
    next_st.meta = bus.raw;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= {(2 * W){`IRP_PIN_IDLE}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.synced = st.stable;

endmodule

// ===== irp_partner.sv
module irp_partner (
  // Clock.
  input wire logic clock,
  // Interrupt sources and host port enable.
  output logic [3:0] extIrqN,
  output logic hostPortEnablePin,
  // Shared pin as driven by the device.
  input wire logic pinOut,
  input wire logic pinOe,
  output logic pinIn
);
  timeunit 1ns;
  timeprecision 1ns;

  logic nmiLevel;

  initial
  begin
    extIrqN = 4'hf;
    nmiLevel = 1'h1;
    hostPortEnablePin = 1'h1;
  end

  // The pin has a pull-up, so a released wire reads high.
  assign pinIn = pinOe ? pinOut : nmiLevel;

  // Index 4 is the shared pin, the rest are the maskable lines.
  task automatic pulse_line(input int idx);
    @(posedge clock);
    if (idx < 4)
      extIrqN[idx] <= 1'h0;
    else
      nmiLevel <= 1'h0;
    repeat (3) @(posedge clock);
    extIrqN <= 4'hf;
    nmiLevel <= 1'h1;
  endtask

  // A board with no host attached keeps this low.
  task automatic set_host_enable(input logic en);
    @(posedge clock);
    hostPortEnablePin <= en;
  endtask
endmodule

// ===== irp_top_tb.sv
module irp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [3:0] extIrqN, irqEnable, flagClear, irqFlag;
  logic globalIrqMask, nmiPending, cpuIrqTake, irqRequest, fetchValid, coreRunN;
  logic [23:0] fetchAddr;
  logic timerSelectWe, timerSelectData, timerSelect, vectorPageWe, extBusCtrlWe;
  logic [15:0] vectorPageData, extBusCtrlData, extBusCtrl;
  logic pinIn, pinOut, pinOe, watchdogDriveEn, watchdogDriveValue, watchdogPinIn;
  logic irqAcknowledgeN, irqAcknowledgeOe, hostPortEnablePin, hostIrqSet, hostIrqClear;
  logic hostInterruptOutN, hostInterruptOe, hostPortOe, holdGrant, holdPinOe;
  logic [1:0] extClockHoldTristate, extMemClockOe;
  logic trstN, emulationPinZero, emulationOffPinN;
  int error_cnt = 0;
  int total_checks = 0;
  int cycleCnt = 0;

  always #50 clock = ~clock;

  irp_partner u_irp_partner (.clock(clock), .extIrqN(extIrqN), .hostPortEnablePin(hostPortEnablePin),
    .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  irp_top u_irp_top (.clock(clock), .rstn(rstn), .extIrqN(extIrqN), .irqEnable(irqEnable),
    .globalIrqMask(globalIrqMask), .flagClear(flagClear), .irqFlag(irqFlag), .nmiPending(nmiPending),
    .cpuIrqTake(cpuIrqTake), .irqRequest(irqRequest), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .coreRunN(coreRunN), .timerSelectWe(timerSelectWe), .timerSelectData(timerSelectData),
    .timerSelect(timerSelect), .vectorPageWe(vectorPageWe), .vectorPageData(vectorPageData),
    .extBusCtrlWe(extBusCtrlWe), .extBusCtrlData(extBusCtrlData), .extBusCtrl(extBusCtrl),
    .sharedIrqWatchdogPinIn(pinIn), .sharedIrqWatchdogPinOut(pinOut), .sharedIrqWatchdogPinOe(pinOe),
    .watchdogDriveEn(watchdogDriveEn), .watchdogDriveValue(watchdogDriveValue),
    .watchdogPinIn(watchdogPinIn), .irqAcknowledgeN(irqAcknowledgeN), .irqAcknowledgeOe(irqAcknowledgeOe),
    .hostPortEnablePin(hostPortEnablePin), .hostIrqSet(hostIrqSet), .hostIrqClear(hostIrqClear),
    .hostInterruptOutN(hostInterruptOutN), .hostInterruptOe(hostInterruptOe), .hostPortOe(hostPortOe),
    .holdGrant(holdGrant), .extClockHoldTristate(extClockHoldTristate), .extMemClockOe(extMemClockOe),
    .holdPinOe(holdPinOe), .trstN(trstN), .emulationPinZero(emulationPinZero),
    .emulationOffPinN(emulationOffPinN));

  // ****************************************************************
  // Checking and closing.
  // ****************************************************************
  task automatic check_value(input string what, input logic [23:0] expv, input logic [23:0] got);
    total_checks++;
    if (got !== expv)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycleCnt++;
    if (cycleCnt == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // Waits for a vector fetch and checks its address and acknowledge.
  task automatic wait_fetch(input string what, input logic [23:0] addr, input logic ackv);
    for (int n = 0; n < 10; n++)
    begin
      @(posedge clock);
      #1;
      if (fetchValid === 1'h1)
        break;
    end
    check_value({what, " valid"}, 1'h1, fetchValid);
    check_value({what, " addr"}, addr, fetchAddr);
    check_value({what, " ack"}, ackv, irqAcknowledgeN);
  endtask

  task automatic take_irq(input string what, input logic [23:0] addr);
    @(posedge clock);
    cpuIrqTake <= 1'h1;
    wait_fetch(what, addr, 1'h0);
    @(posedge clock);
    cpuIrqTake <= 1'h0;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic test_reset();
    repeat (3) @(posedge clock);
    #1;
    check_value("host int oe", 1'h0, hostInterruptOe);
    check_value("host port oe", 1'h0, hostPortOe);
    check_value("ack reset", 2'h3, {irqAcknowledgeN, irqAcknowledgeOe});
    check_value("bus ctrl reset", 16'hffff, extBusCtrl);
    check_value("select reset", 1'h0, timerSelect);
    check_value("core held", 1'h1, coreRunN);
    @(posedge clock);
    rstn <= 1'h1;
    wait_fetch("reset vector", 24'hffff00, 1'h1);
    check_value("core run", 1'h0, coreRunN);
    check_value("host int after", 2'h3, {hostInterruptOutN, hostInterruptOe});
    $display("test reset done");
  endtask

  task automatic test_maskable();
    @(posedge clock);
    irqEnable <= 4'hf;
    for (int i = 0; i < 4; i++)
    begin
      u_irp_partner.pulse_line(i);
      repeat (3) @(posedge clock);
      #1;
      check_value("flag", 4'h1 << i, irqFlag);
      check_value("request", 1'h1, irqRequest);
      take_irq("maskable", {16'hffff, 5'(i + 2), 3'h0});
      check_value("flag taken", 4'h0, irqFlag);
    end
    @(posedge clock);
    irqEnable <= 4'hd;
    u_irp_partner.pulse_line(1);
    repeat (3) @(posedge clock);
    #1;
    check_value("disabled flag", 4'h2, irqFlag);
    check_value("disabled req", 1'h0, irqRequest);
    @(posedge clock);
    irqEnable <= 4'hf;
    globalIrqMask <= 1'h1;
    @(posedge clock);
    #1;
    check_value("masked req", 1'h0, irqRequest);
    @(posedge clock);
    flagClear <= 4'h2;
    @(posedge clock);
    flagClear <= 4'h0;
    @(posedge clock);
    #1;
    check_value("cleared", 4'h0, irqFlag);
    $display("test maskable done");
  endtask

  task automatic test_nmi();
    @(posedge clock);
    irqEnable <= 4'h0;
    vectorPageWe <= 1'h1;
    vectorPageData <= 16'h1234;
    @(posedge clock);
    vectorPageWe <= 1'h0;
    u_irp_partner.pulse_line(4);
    repeat (3) @(posedge clock);
    #1;
    check_value("nmi pending", 2'h3, {nmiPending, irqRequest});
    take_irq("nmi", {16'h1234, 5'h01, 3'h0});
    @(posedge clock);
    globalIrqMask <= 1'h0;
    timerSelectWe <= 1'h1;
    timerSelectData <= 1'h1;
    watchdogDriveEn <= 1'h1;
    @(posedge clock);
    timerSelectWe <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    check_value("select", 1'h1, timerSelect);
    check_value("wdt drive", 3'h4, {pinOe, pinOut, watchdogPinIn});
    $display("test nmi done");
  endtask

  task automatic test_pins();
    @(posedge clock);
    hostIrqSet <= 1'h1;
    @(posedge clock);
    hostIrqSet <= 1'h0;
    @(posedge clock);
    #1;
    check_value("host int set", 1'h0, hostInterruptOutN);
    @(posedge clock);
    hostIrqClear <= 1'h1;
    @(posedge clock);
    hostIrqClear <= 1'h0;
    @(posedge clock);
    #1;
    check_value("host int clear", 1'h1, hostInterruptOutN);
    u_irp_partner.set_host_enable(1'h0);
    #1;
    check_value("port off", 2'h0, {hostPortOe, hostInterruptOe});
    u_irp_partner.set_host_enable(1'h1);
    holdGrant <= 1'h1;
    extClockHoldTristate <= 2'h2;
    extBusCtrlWe <= 1'h1;
    extBusCtrlData <= 16'h00a5;
    @(posedge clock);
    extBusCtrlWe <= 1'h0;
    #1;
    check_value("hold pins", 1'h0, holdPinOe);
    check_value("hold clocks", 2'h1, extMemClockOe);
    check_value("bus ctrl", 16'h00a5, extBusCtrl);
    @(posedge clock);
    holdGrant <= 1'h0;
    trstN <= 1'h0;
    emulationPinZero <= 1'h1;
    emulationOffPinN <= 1'h0;
    @(posedge clock);
    #1;
    check_value("off mode", 3'h0, {irqAcknowledgeOe, hostInterruptOe, holdPinOe});
    $display("test pins done");
  endtask

  initial
  begin
    {irqEnable, flagClear, globalIrqMask, cpuIrqTake} = '0;
    {timerSelectWe, timerSelectData, vectorPageWe, vectorPageData} = '0;
    {extBusCtrlWe, extBusCtrlData, watchdogDriveEn, watchdogDriveValue} = '0;
    {hostIrqSet, hostIrqClear, holdGrant, extClockHoldTristate, emulationPinZero} = '0;
    trstN = 1'h1;
    emulationOffPinN = 1'h1;
    test_reset();
    test_maskable();
    test_nmi();
    test_pins();
    final_report();
  end
endmodule
